/* host_bus_pkg.sv */
// host_bus_pkg: constants for the processor bus port
// assumes nothing beyond a sv-2012 compiler
package host_bus_pkg;
  localparam int          DATA_W             = 16;
  localparam int          CMD_W              = 8;
  localparam logic [7:0]  IDX_DMA_SETUP_RD   = 8'h21;
  localparam logic [7:0]  IDX_DMA_SETUP_WR   = 8'hA1;
  localparam logic [7:0]  IDX_COUNT_RD       = 8'h22;
  localparam logic [7:0]  IDX_COUNT_WR       = 8'hA2;
  localparam logic [7:0]  IDX_PART_ID_RD     = 8'h27;
  localparam logic [7:0]  IDX_BUFFER_RD      = 8'h40;
  localparam logic [7:0]  IDX_BUFFER_WR      = 8'hC0;
  localparam logic [7:0]  IDX_SCRATCH32_RD   = 8'h28;
  localparam logic [7:0]  IDX_SCRATCH32_WR   = 8'hA8;
  localparam int          BIT_COUNTER_SEL    = 2;
  localparam int          BIT_DMA_ENABLE     = 4;
  localparam int          BIT_BURST          = 5;
  localparam int          BIT_DIR_WRITE      = 0;
  localparam logic [15:0] DMA_SETUP_RST      = 16'h0000;
  localparam logic [15:0] COUNT_RST          = 16'h0000;
  // arbitrary neutral identification value
  localparam logic [15:0] PART_ID_DEFAULT    = 16'h5A01;
  localparam logic [1:0]  SYNC_MSB           = 2'h2;
  localparam int          BURST_WORDS        = 4;
endpackage

/* pin_sync.sv */
// pin_sync: three-flop synchroniser with agreement filter
// assumes the input is asynchronous to SYS_CLK_I
`timescale 1ns/1ns
module pin_sync
  import host_bus_pkg::*;
#(
  parameter int   W     = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  // ---------------------------------------------------------------
  // sync chain
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      // stages start at the idle level, so no false edge follows reset
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
    end
  end
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // a change is taken only when stages two and three agree
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          level_o[g] <= RST_VAL[g];
        end else if (s2[g] == s3[g]) begin
          level_o[g] <= s3[g];
        end
      end
    end
  endgenerate
endmodule

/* host_cpu_bus_port.sv */
// host_cpu_bus_port: processor command/data port with dma handshake
// assumes strobes, selects and eot arrive asynchronously from pins,
// and the buffer ram sits outside behind a word request interface
`timescale 1ns/1ns
module host_cpu_bus_port
  import host_bus_pkg::*;
#(
  parameter int          BURST_LEN = BURST_WORDS,
  parameter logic [15:0] PART_ID   = PART_ID_DEFAULT
) (
  input  wire logic              SYS_CLK_I,
  input  wire logic              SYS_RST_I,
  input  wire logic              CHIP_SELECT_N_I,
  input  wire logic              COMMAND_DATA_SELECT_I,
  input  wire logic              READ_N_I,
  input  wire logic              WRITE_N_I,
  input  wire logic [DATA_W-1:0] DATA_I,
  output logic      [DATA_W-1:0] DATA_O,
  output logic                   DATA_OE_O,
  output logic                   DMA_REQUEST_OUT_O,
  input  wire logic              DMA_ACKNOWLEDGE_LOW_I,
  input  wire logic              END_OF_TRANSFER_INPUT_I,
  output logic                   BUF_WR_O,
  output logic                   BUF_RD_O,
  output logic      [DATA_W-1:0] BUF_WDATA_O,
  input  wire logic [DATA_W-1:0] BUF_RDATA_I,
  output logic                   DMA_DONE_O
);
  typedef enum {DMA_IDLE, DMA_REQ, DMA_XFER} dma_state_t;

  logic [4:0]        pins;
  logic              cs_n, a0, rd_n, wr_n, ack_n;
  logic              rd_n_d, wr_n_d, ack_n_d;
  logic [DATA_W-1:0] data_s1, data_s2;
  logic [CMD_W-1:0]  command;
  logic              high_half;
  logic [15:0]       dma_setup;
  logic [15:0]       transfer_byte_count;
  logic [31:0]       scratch32;
  logic [15:0]       word_count;
  logic [15:0]       dma_count;
  logic [7:0]        burst_count;
  logic              cycle_dir_set, cycle_dir_wr;
  dma_state_t        dma_state;
  logic              pio_sel, dma_sel, rd_fall, wr_fall, wr_rise, rd_rise;
  logic              word_done, is_buffer, is_buffer_rd, is_buffer_wr;
  logic              internal_end, end_now;
  logic [DATA_W-1:0] next_rdata;
  logic [15:0]       half_count;

  // ---------------------------------------------------------------
  // pin capture
  // ---------------------------------------------------------------
  pin_sync #(
    .W       (5),
    .RST_VAL (5'h1F)
  ) u_sync (
    .clk_i   (SYS_CLK_I),
    .rst_i   (SYS_RST_I),
    .pin_i   ({CHIP_SELECT_N_I, COMMAND_DATA_SELECT_I, READ_N_I, WRITE_N_I,
                DMA_ACKNOWLEDGE_LOW_I}),
    .level_o (pins)
  );
  assign {cs_n, a0, rd_n, wr_n, ack_n} = pins;

  logic eot_lvl;
  pin_sync #(
    .W       (1),
    .RST_VAL (1'b0)
  ) u_eot (
    .clk_i   (SYS_CLK_I),
    .rst_i   (SYS_RST_I),
    .pin_i   (END_OF_TRANSFER_INPUT_I),
    .level_o (eot_lvl)
  );

  // data is copied, not synchronised: the host must hold it from strobe fall
  // until about four clocks after the strobe rises, when the filtered edge lands
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      data_s1 <= '0;
      data_s2 <= '0;
      rd_n_d  <= 1'b1;
      wr_n_d  <= 1'b1;
      ack_n_d <= 1'b1;
    end else begin
      data_s1 <= DATA_I;
      data_s2 <= data_s1;
      rd_n_d  <= rd_n;
      wr_n_d  <= wr_n;
      ack_n_d <= ack_n;
    end
  end

  assign pio_sel = !cs_n;
  // active-low acknowledge, kept one clock for a strobe released with it
  assign dma_sel = (!ack_n || !ack_n_d) && dma_state != DMA_IDLE;
  assign rd_fall = rd_n_d && !rd_n;
  assign rd_rise = !rd_n_d && rd_n;
  assign wr_fall = wr_n_d && !wr_n;
  assign wr_rise = !wr_n_d && wr_n;
  assign half_count = {1'b0, transfer_byte_count[15:1]};
  assign is_buffer_rd = command == IDX_BUFFER_RD;
  assign is_buffer_wr = command == IDX_BUFFER_WR;
  assign is_buffer = is_buffer_rd || is_buffer_wr;

  // ---------------------------------------------------------------
  // command phase
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      command <= '0;
    end else if (pio_sel && a0 && wr_rise) begin
      command <= data_s2[CMD_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // data phase sequencing
  // ---------------------------------------------------------------
  assign word_done = pio_sel && !a0 && (rd_rise || wr_rise) && (!cycle_dir_set || cycle_dir_wr == wr_rise);
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      high_half     <= 1'b0;
      word_count    <= '0;
      cycle_dir_set <= 1'b0;
      cycle_dir_wr  <= 1'b0;
    end else if (pio_sel && a0 && wr_rise) begin
      high_half     <= 1'b0;
      word_count    <= '0;
      cycle_dir_set <= 1'b0;
    end else if (word_done) begin
      high_half     <= !high_half;
      word_count    <= word_count + 16'h0001;
      if (!cycle_dir_set) begin
        cycle_dir_set <= 1'b1;
        cycle_dir_wr  <= wr_rise;
      end
    end
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  logic wr_ok;
  assign wr_ok = pio_sel && !a0 && wr_rise && (!cycle_dir_set || cycle_dir_wr);
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      dma_setup           <= DMA_SETUP_RST;
      transfer_byte_count <= COUNT_RST;
      scratch32           <= '0;
    end else if (wr_ok) begin
      case (command)
        IDX_DMA_SETUP_WR: begin
          dma_setup <= data_s2;
        end
        IDX_COUNT_WR: begin
          transfer_byte_count <= data_s2;
        end
        IDX_SCRATCH32_WR: begin
          if (high_half) begin
            scratch32[31:16] <= data_s2;
          end else begin
            scratch32[15:0] <= data_s2;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_comb begin
    next_rdata = '0;
    if (dma_sel || is_buffer_rd) begin
      next_rdata = BUF_RDATA_I;
    end else begin
      case (command)
        IDX_DMA_SETUP_RD: next_rdata = dma_setup;
        IDX_COUNT_RD:     next_rdata = transfer_byte_count;
        IDX_PART_ID_RD:   next_rdata = PART_ID;
        IDX_SCRATCH32_RD: next_rdata = high_half ? scratch32[31:16] : scratch32[15:0];
        default:          next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      DATA_O    <= '0;
      DATA_OE_O <= 1'b0;
    end else begin
      DATA_O    <= next_rdata;
      DATA_OE_O <= !rd_n && ((pio_sel && !a0) || dma_sel);
    end
  end

  // ---------------------------------------------------------------
  // buffer ram word strobes
  // ---------------------------------------------------------------
  logic buf_pio_ok;
  // stop at half the byte count
  assign buf_pio_ok = pio_sel && !a0 && is_buffer && word_count < half_count;
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      BUF_WR_O    <= 1'b0;
      BUF_RD_O    <= 1'b0;
      BUF_WDATA_O <= '0;
    end else begin
      BUF_WR_O    <= (buf_pio_ok && is_buffer_wr && wr_ok) ||
                     (dma_sel && dma_setup[BIT_DIR_WRITE] && wr_rise);
      BUF_RD_O    <= (buf_pio_ok && is_buffer_rd && rd_rise && word_done) ||
                     (dma_sel && !dma_setup[BIT_DIR_WRITE] && rd_rise);
      BUF_WDATA_O <= data_s2;
    end
  end

  // ---------------------------------------------------------------
  // dma engine
  // ---------------------------------------------------------------
  logic dma_word;
  assign dma_word = dma_sel && (rd_rise || wr_rise);
  assign internal_end = dma_setup[BIT_COUNTER_SEL] && dma_word &&
                        (dma_count + 16'h0002) >= transfer_byte_count;
  assign end_now = eot_lvl || internal_end;

  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      dma_state   <= DMA_IDLE;
      dma_count   <= '0;
      burst_count <= '0;
      DMA_DONE_O  <= 1'b0;
    end else begin
      DMA_DONE_O <= 1'b0;
      case (dma_state)
        DMA_IDLE: begin
          dma_count <= '0;
          if (dma_setup[BIT_DMA_ENABLE] && !eot_lvl) begin
            dma_state <= DMA_REQ;
          end
        end
        DMA_REQ: begin
          burst_count <= '0;
          if (end_now || !dma_setup[BIT_DMA_ENABLE]) begin
            dma_state  <= DMA_IDLE;
            DMA_DONE_O <= 1'b1;
          end else if (!ack_n) begin
            dma_state <= DMA_XFER;
          end
        end
        DMA_XFER: begin
          if (dma_word) begin
            dma_count   <= dma_count + 16'h0002;
            burst_count <= burst_count + 8'h01;
          end
          if (end_now) begin
            dma_state  <= DMA_IDLE;
            DMA_DONE_O <= 1'b1;
          end else if (dma_word && (!dma_setup[BIT_BURST] ||
                       burst_count == 8'(BURST_LEN - 1))) begin
            dma_state <= DMA_REQ;
          end
        end
        default: begin
          dma_state <= DMA_IDLE;
        end
      endcase
    end
  end

  assign DMA_REQUEST_OUT_O = dma_state == DMA_REQ;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_cmd_port_no_drive;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      (pio_sel && a0 && ack_n) |=> !DATA_OE_O;
  endproperty
  a_cmd_port_no_drive: assert property (p_cmd_port_no_drive) else $error("drive on command port");

  property p_read_drives;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      (!rd_n && pio_sel && !a0) |=> DATA_OE_O;
  endproperty
  a_read_drives: assert property (p_read_drives) else $error("no drive on data read");

  property p_idle_off;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      (cs_n && !dma_sel) |=> !DATA_OE_O;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("driver on while idle");

  property p_id_value;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      (command == IDX_PART_ID_RD && !dma_sel) |=> DATA_O == PART_ID;
  endproperty
  a_id_value: assert property (p_id_value) else $error("bad identification");

  property p_count_write;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      (wr_ok && command == IDX_COUNT_WR) |=> transfer_byte_count == $past(data_s2);
  endproperty
  a_count_write: assert property (p_count_write) else $error("count not stored");

  property p_half_toggle;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      (word_done && !(a0 && wr_rise)) |=> high_half != $past(high_half);
  endproperty
  a_half_toggle: assert property (p_half_toggle) else $error("half order broken");

  property p_buf_limit;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      (pio_sel && !a0 && is_buffer && word_count >= half_count && !dma_sel) |=> !BUF_WR_O && !BUF_RD_O;
  endproperty
  a_buf_limit: assert property (p_buf_limit) else $error("buffer past count");

  property p_end_stops;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      (dma_state == DMA_XFER && eot_lvl) |=> dma_state == DMA_IDLE && DMA_DONE_O;
  endproperty
  a_end_stops: assert property (p_end_stops) else $error("dma not ended");

  property p_single_rerequest;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      (dma_state == DMA_XFER && dma_word && !end_now && !dma_setup[BIT_BURST]) |=> DMA_REQUEST_OUT_O;
  endproperty
  a_single_rerequest: assert property (p_single_rerequest) else $error("no new request");

  c_dma_done: cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I) DMA_DONE_O);
  c_internal_end: cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I) internal_end);
  c_buf_write: cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I) BUF_WR_O && !dma_sel);
  c_id_read: cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I) DATA_OE_O && command == IDX_PART_ID_RD);
endmodule

/* buf_ram_model.sv */
// buf_ram_model: show-ahead word fifo standing behind the buffer request port
// assumes one-cycle write and pop pulses sampled on the rising clock edge
`timescale 1ns/1ns
module buf_ram_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [15:0] wdata_i,
  output logic      [15:0] rdata_o,
  output logic      [7:0]  wr_count_o,
  output logic      [7:0]  rd_count_o
);
  logic [15:0] store[$];
  logic [15:0] last;

  // ---------------------------------------------------------------
  // word store
  // ---------------------------------------------------------------
  // an empty store shows the inverse of the last word, never a stale copy
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      store.delete();
      last = 16'h0000;
      wr_count_o <= 8'h00;
      rd_count_o <= 8'h00;
      rdata_o <= 16'hFFFF;
    end else begin
      if (rd_i === 1'b1 && store.size() > 0) begin
        last = store.pop_front();
        rd_count_o <= rd_count_o + 8'h01;
      end
      if (wr_i === 1'b1) begin
        store.push_back(wdata_i);
        wr_count_o <= wr_count_o + 8'h01;
      end
      rdata_o <= (store.size() > 0) ? store[0] : ~last;
    end
  end
endmodule

/* host_cpu_bus_port_tb.sv */
// host_cpu_bus_port_tb: register, buffer and dma sequences on the processor bus
// assumes the bus port and the buffer model above; strobes move on falling edges
`timescale 1ns/1ns
module host_cpu_bus_port_tb;
  import host_bus_pkg::*;
  // arbitrary neutral identification value
  localparam logic [15:0] TB_PART_ID = 16'hC3E1;
  logic        clk;
  logic        rst;
  logic        cs_n;
  logic        a0;
  logic        rd_n;
  logic        wr_n;
  logic        ack_n;
  logic        end_of_transfer_input;
  logic        data_oe;
  logic        req;
  logic        buf_wr;
  logic        buf_rd;
  logic        done;
  logic        oe_seen;
  logic [15:0] data_i;
  logic [15:0] data_o;
  logic [15:0] buf_wdata;
  logic [15:0] buf_rdata;
  logic [15:0] q;
  logic [7:0]  wr_cnt;
  logic [7:0]  rd_cnt;
  int          bad_count;
  int          checked;
  int          done_cnt;

  host_cpu_bus_port #(.BURST_LEN(BURST_WORDS), .PART_ID(TB_PART_ID)) u_host_cpu_bus_port (
    .SYS_CLK_I(clk), .SYS_RST_I(rst), .CHIP_SELECT_N_I(cs_n), .COMMAND_DATA_SELECT_I(a0),
    .READ_N_I(rd_n), .WRITE_N_I(wr_n), .DATA_I(data_i), .DATA_O(data_o), .DATA_OE_O(data_oe),
    .DMA_REQUEST_OUT_O(req), .DMA_ACKNOWLEDGE_LOW_I(ack_n), .END_OF_TRANSFER_INPUT_I(end_of_transfer_input),
    .BUF_WR_O(buf_wr), .BUF_RD_O(buf_rd), .BUF_WDATA_O(buf_wdata), .BUF_RDATA_I(buf_rdata),
    .DMA_DONE_O(done));

  buf_ram_model u_buf_ram_model (
    .clk_i(clk), .rst_i(rst), .wr_i(buf_wr), .rd_i(buf_rd), .wdata_i(buf_wdata),
    .rdata_o(buf_rdata), .wr_count_o(wr_cnt), .rd_count_o(rd_cnt));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) if (done === 1'b1) done_cnt++;

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one strobe phase, held 10 clocks low and 10 high; the caller lowers ack,
  // which rises with the strobe; data stays until the filtered edge is taken
  task automatic phase(input logic sel, input logic cmd, input logic wr, input logic [15:0] d);
    @(negedge clk);
    cs_n = ~sel;
    a0 = cmd;
    data_i = d;
    if (wr) wr_n = 1'b0;
    else rd_n = 1'b0;
    repeat (10) @(negedge clk);
    q = data_o;
    oe_seen = data_oe;
    wr_n = 1'b1;
    rd_n = 1'b1;
    ack_n = 1'b1;
    repeat (2) @(negedge clk);
    cs_n = 1'b1;
    repeat (8) @(negedge clk);
    data_i = ~d;
  endtask

  task automatic reg_wr(input logic [7:0] idx, input logic [15:0] val);
    phase(1'b1, 1'b1, 1'b1, {8'h00, idx});
    phase(1'b1, 1'b0, 1'b1, val);
  endtask

  task automatic reg_rd(input logic [7:0] idx, input logic [15:0] exp, input string name);
    phase(1'b1, 1'b1, 1'b1, {8'h00, idx});
    phase(1'b1, 1'b0, 1'b0, 16'h0000);
    check(name, q, exp);
    check("read_oe", {15'h0000, oe_seen}, 16'h0001);
  endtask

  task automatic dma_word(input logic wr, input logic [15:0] d);
    ack_n = 1'b0;
    phase(1'b0, 1'b0, wr, d);
  endtask

  task automatic wait_req();
    int n;
    n = 0;
    while (req !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    check("request", {15'h0000, req}, 16'h0001);
  endtask

  task automatic wait_done(input int exp);
    int n;
    n = 0;
    while (done_cnt != exp && n < 100) begin
      @(negedge clk);
      n++;
    end
    check("dma_done", 16'(done_cnt), 16'(exp));
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  // whole run is near 1400 clocks, so this only trips on a hang
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end

  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    cs_n = 1'b1;
    a0 = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    ack_n = 1'b1;
    end_of_transfer_input = 1'b0;
    data_i = 16'h0000;
    q = 16'h0000;
    oe_seen = 1'b0;
    bad_count = 0;
    checked = 0;
    done_cnt = 0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    check("idle_oe", {15'h0000, data_oe}, 16'h0000);
    reg_rd(IDX_DMA_SETUP_RD, DMA_SETUP_RST, "dma_setup_rst");
    reg_rd(IDX_COUNT_RD, COUNT_RST, "count_rst");
    reg_rd(IDX_PART_ID_RD, TB_PART_ID, "part_id");
    reg_wr(IDX_PART_ID_RD, 16'h1111);
    reg_rd(IDX_PART_ID_RD, TB_PART_ID, "part_id_ro");
    $display("test reset_and_id done");

    reg_wr(IDX_COUNT_WR, 16'h0006);
    phase(1'b0, 1'b0, 1'b1, 16'hFFFF);
    reg_rd(IDX_COUNT_RD, 16'h0006, "count");
    phase(1'b1, 1'b1, 1'b0, 16'h0000);
    check("cmd_port_oe", {15'h0000, oe_seen}, 16'h0000);
    reg_wr(IDX_DMA_SETUP_WR, 16'h0004);
    reg_rd(IDX_DMA_SETUP_RD, 16'h0004, "dma_setup");
    reg_rd(8'h3F, 16'h0000, "unknown_index");
    reg_wr(IDX_SCRATCH32_WR, 16'h1234);
    phase(1'b1, 1'b0, 1'b1, 16'hABCD);
    phase(1'b1, 1'b1, 1'b1, {8'h00, IDX_SCRATCH32_RD});
    phase(1'b1, 1'b0, 1'b0, 16'h0000);
    check("scratch_low", q, 16'h1234);
    phase(1'b1, 1'b0, 1'b0, 16'h0000);
    check("scratch_high", q, 16'hABCD);
    $display("test registers done");

    // six bytes: the fourth word must be dropped
    phase(1'b1, 1'b1, 1'b1, {8'h00, IDX_BUFFER_WR});
    for (int i = 1; i <= 4; i++) phase(1'b1, 1'b0, 1'b1, 16'(i * 16'h1111));
    check("pio_words_in", {8'h00, wr_cnt}, 16'h0003);
    phase(1'b1, 1'b1, 1'b1, {8'h00, IDX_BUFFER_RD});
    phase(1'b1, 1'b0, 1'b0, 16'h0000);
    check("pio_word", q, 16'h1111);
    phase(1'b1, 1'b0, 1'b1, 16'h5555);
    check("pio_dropped", {8'h00, wr_cnt}, 16'h0003);
    for (int i = 2; i <= 3; i++) begin
      phase(1'b1, 1'b0, 1'b0, 16'h0000);
      check("pio_word", q, 16'(i * 16'h1111));
    end
    check("pio_words_out", {8'h00, rd_cnt}, 16'h0003);
    $display("test pio_buffer done");

    reg_wr(IDX_COUNT_WR, 16'h0100);
    reg_wr(IDX_DMA_SETUP_WR, 16'h0011);
    for (int i = 0; i < 2; i++) begin
      wait_req();
      dma_word(1'b1, 16'hA0A0 + 16'(i));
    end
    end_of_transfer_input = 1'b1;
    wait_done(1);
    reg_wr(IDX_DMA_SETUP_WR, 16'h0000);
    end_of_transfer_input = 1'b0;
    check("dma_single_words", {8'h00, wr_cnt}, 16'h0005);
    $display("test dma_single_eot done");

    reg_wr(IDX_COUNT_WR, 16'h0008);
    reg_wr(IDX_DMA_SETUP_WR, 16'h0035);
    wait_req();
    for (int i = 0; i < 4; i++) begin
      dma_word(1'b1, 16'hB0B0 + 16'(i));
      if (i < 3) check("burst_req_low", {15'h0000, req}, 16'h0000);
    end
    wait_done(2);
    reg_wr(IDX_DMA_SETUP_WR, 16'h0000);
    wait_done(3);
    check("burst_words", {8'h00, wr_cnt}, 16'h0009);
    $display("test dma_burst_counter done");

    // read direction pops the words the single transfer stored
    reg_wr(IDX_COUNT_WR, 16'h0004);
    reg_wr(IDX_DMA_SETUP_WR, 16'h0014);
    for (int i = 0; i < 2; i++) begin
      wait_req();
      dma_word(1'b0, 16'h0000);
      check("dma_read", q, 16'hA0A0 + 16'(i));
    end
    wait_done(4);
    reg_wr(IDX_DMA_SETUP_WR, 16'h0000);
    check("dma_read_pops", {8'h00, rd_cnt}, 16'h0005);
    $display("test dma_read_counter done");
    tally_and_finish();
  end
endmodule
